// *** bwc_consts.svh ***
// Constants for the byte-wise CRC16 generator: offsets, fields, values.
`ifndef BWC_CONSTS_SVH
`define BWC_CONSTS_SVH
`define BWC_OFF_CONTROL 4'h0
`define BWC_OFF_INPUT 4'h4
`define BWC_OFF_SUM_LOW 4'h8
`define BWC_OFF_SUM_HIGH 4'hC
`define BWC_POLYNOMIAL_SELECT_CCITT 16'h1021
`define BWC_POLYNOMIAL_SELECT_CRC16 16'h8005
`define BWC_POLYNOMIAL_SELECT_BIT 0
`define BWC_BYTE_ZERO 8'h00
`define BWC_SUM_ZERO 16'h0000
`define BWC_WORD_ZERO 32'h0000_0000
`define BWC_RESP_OKAY 2'b00
`define BWC_RESP_SLVERR 2'b10
`define BWC_ADDR_LSB 2
`define BWC_ADDR_MSB 3
`define BWC_BITS_PER_BYTE 8
`endif

// *** bwc_crc16_monitor.sv ***
// Concurrent checks on the ports of the CRC16 register slave.
`timescale 1ns/100ps
`default_nettype none
`include "bwc_consts.svh"
module bwc_crc16_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // Helper state
  // Remember the read address so the answer can be judged by it.
  logic [3:0] rd_addr_q;
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Assertions
  // Both halves taken at one edge are held one cycle, then answered.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  a_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000) else $error("upper lanes set");
  a_ctrl_zero: assert property (s_axi_rvalid &&
    rd_addr_q == `BWC_OFF_CONTROL |-> s_axi_rdata[7:1] == 7'h00)
    else $error("control high bits set");
  a_unmapped_err: assert property (s_axi_rvalid &&
    rd_addr_q[1:0] != 2'h0 |-> s_axi_rresp == `BWC_RESP_SLVERR)
    else $error("unmapped read not refused");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == `BWC_RESP_SLVERR);
  c_control: cover property (s_axi_rvalid && rd_addr_q == `BWC_OFF_CONTROL);
endmodule
bind bwc_crc16_top bwc_crc16_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** bwc_crc16_top.sv ***
// AXI4-Lite slave byte-wise CRC16 generator with selectable polynomial.
// Function
// - Each input byte write triggers one checksum update with the held sum.
// - Checksum kept in low register bits 7..0 and high register bits 15..8.
// - Control bit 0 picks polynomial: 0 CCITT, 1 CRC-16.
// - Only those two polynomials exist; no other can be chosen.
// - Update completes within one cycle after the write.
// - Input byte XORs into checksum high byte to start each update.
// - Each bit step shifts left one, inserting zero at LSB.
// - When a one shifts out, shifted value XORs with 8005H for CRC-16 or 1021H for CCITT.
// - Eight bit steps per byte; result becomes the new checksum.
// - Control bits 7..1 are unimplemented and read zero.
// - Bytes 78,56,34,12 from zero give D0FA CCITT, 5C43 CRC-16.
`timescale 1ns/100ps
`default_nettype none
`include "bwc_consts.svh"
module bwc_crc16_top
  import bwc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // Write channel capture
  // ==========================================================
  // Address and data are latched independently so either may come first.
  logic aw_full_q;
  logic aw_full_d;
  logic [3:0] aw_addr_q;
  logic [3:0] aw_addr_d;
  logic w_full_q;
  logic w_full_d;
  logic [7:0] w_data_q;
  logic [7:0] w_data_d;
  logic w_strb_q;
  logic w_strb_d;
  logic b_valid_q;
  logic b_valid_d;
  logic [1:0] b_resp_q;
  logic [1:0] b_resp_d;

  // Ready while the slot is empty and no response is pending.
  assign s_axi_awready = !aw_full_q && !b_valid_q;
  assign s_axi_wready = !w_full_q && !b_valid_q;

  wire logic aw_take;
  wire logic w_take;
  wire logic wr_fire;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  // The write executes once both halves are held.
  assign wr_fire = aw_full_q && w_full_q && !b_valid_q;

  assign aw_full_d = wr_fire ? 1'b0 : (aw_full_q || aw_take);
  assign aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
  assign w_full_d = wr_fire ? 1'b0 : (w_full_q || w_take);
  assign w_data_d = w_take ? s_axi_wdata[7:0] : w_data_q;
  // Registers are a byte wide, so only lane zero matters.
  assign w_strb_d = w_take ? s_axi_wstrb[0] : w_strb_q;

  // Write address decode.
  wire logic wr_hit;
  bwc_reg_type wr_sel;
  bwc_decode u_wr_decode (
    .addr(aw_addr_q),
    .hit(wr_hit),
    .sel(wr_sel)
  );

  assign b_valid_d = wr_fire ? 1'b1 :
                     ((b_valid_q && s_axi_bready) ? 1'b0 : b_valid_q);
  assign b_resp_d = wr_fire ? (wr_hit ? `BWC_RESP_OKAY : `BWC_RESP_SLVERR)
                            : b_resp_q;
  assign s_axi_bvalid = b_valid_q;
  assign s_axi_bresp = b_resp_q;

  // ==========================================================
  // Register file and CRC engine
  // ==========================================================
  bwc_wreq_type wreq;
  assign wreq.index = wr_sel;
  assign wreq.data = w_data_q;
  assign wreq.strobe = wr_fire && wr_hit && w_strb_q;

  logic polynomial_select_select_q;
  logic polynomial_select_select_d;
  logic [7:0] input_byte_q;
  logic [7:0] input_byte_d;
  logic [15:0] running_checksum_q;
  logic [15:0] running_checksum_d;
  logic [15:0] next_sum;

  // The step works on the held checksum and selected polynomial.
  bwc_crc_step u_step (
    .sum_in(running_checksum_q),
    .data_in(wreq.data),
    .polynomial_select_sel(polynomial_select_select_q),
    .sum_out(next_sum)
  );

  wire logic wr_control;
  wire logic wr_input;
  wire logic wr_low;
  wire logic wr_high;
  assign wr_control = wreq.strobe && (wreq.index == BWC_REG_CONTROL);
  assign wr_input = wreq.strobe && (wreq.index == BWC_REG_INPUT);
  assign wr_low = wreq.strobe && (wreq.index == BWC_REG_SUM_LOW);
  assign wr_high = wreq.strobe && (wreq.index == BWC_REG_SUM_HIGH);

  // Only bit 0 of control is stored.
  assign polynomial_select_select_d = wr_control ? wreq.data[`BWC_POLYNOMIAL_SELECT_BIT]
                                    : polynomial_select_select_q;
  assign input_byte_d = wr_input ? wreq.data : input_byte_q;
  // An input byte write replaces the whole sum in the same edge it lands.
  assign running_checksum_d =
    wr_input ? next_sum :
    wr_low ? {running_checksum_q[15:8], wreq.data} :
    wr_high ? {wreq.data, running_checksum_q[7:0]} :
    running_checksum_q;

  // ==========================================================
  // Read channel
  // ==========================================================
  logic r_valid_q;
  logic r_valid_d;
  logic [31:0] r_data_q;
  logic [31:0] r_data_d;
  logic [1:0] r_resp_q;
  logic [1:0] r_resp_d;

  assign s_axi_arready = !r_valid_q;
  wire logic ar_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  wire logic rd_hit;
  bwc_reg_type rd_sel;
  bwc_decode u_rd_decode (
    .addr(s_axi_araddr),
    .hit(rd_hit),
    .sel(rd_sel)
  );

  // Upper bits of each word and control bits 7..1 read as zero.
  logic [7:0] rd_byte;
  always_comb
  begin
    case (rd_sel)
      BWC_REG_CONTROL: rd_byte = {7'h00, polynomial_select_select_q};
      BWC_REG_INPUT: rd_byte = input_byte_q;
      BWC_REG_SUM_LOW: rd_byte = running_checksum_q[7:0];
      BWC_REG_SUM_HIGH: rd_byte = running_checksum_q[15:8];
      default: rd_byte = `BWC_BYTE_ZERO;
    endcase
  end

  assign r_valid_d = ar_take ? 1'b1 :
                     ((r_valid_q && s_axi_rready) ? 1'b0 : r_valid_q);
  assign r_data_d = ar_take ? (rd_hit ? {24'h000000, rd_byte} : `BWC_WORD_ZERO)
                            : r_data_q;
  assign r_resp_d = ar_take ? (rd_hit ? `BWC_RESP_OKAY : `BWC_RESP_SLVERR)
                            : r_resp_q;
  assign s_axi_rvalid = r_valid_q;
  assign s_axi_rdata = r_data_q;
  assign s_axi_rresp = r_resp_q;

  // ==========================================================
  // State registers
  // ==========================================================
  // Bus handshake state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      b_valid_q <= 1'b0;
      r_valid_q <= 1'b0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      b_valid_q <= b_valid_d;
      r_valid_q <= r_valid_d;
    end
  end

  // Payload holders; reset keeps outputs defined from the start.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_q <= `BWC_OFF_CONTROL;
      w_data_q <= `BWC_BYTE_ZERO;
      w_strb_q <= 1'b0;
      b_resp_q <= `BWC_RESP_OKAY;
      r_data_q <= `BWC_WORD_ZERO;
      r_resp_q <= `BWC_RESP_OKAY;
    end
    else
    begin
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      b_resp_q <= b_resp_d;
      r_data_q <= r_data_d;
      r_resp_q <= r_resp_d;
    end
  end

  // CRC registers all clear to zero at reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      polynomial_select_select_q <= 1'b0;
      input_byte_q <= `BWC_BYTE_ZERO;
      running_checksum_q <= `BWC_SUM_ZERO;
    end
    else
    begin
      polynomial_select_select_q <= polynomial_select_select_d;
      input_byte_q <= input_byte_d;
      running_checksum_q <= running_checksum_d;
    end
  end

  // Protection bits carry no meaning for this block.
  wire logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8],
                         s_axi_wstrb[3:1]};
endmodule
`default_nettype wire

// *** bwc_crc16_top_bench.sv ***
// Self-checking bench for the CRC16 register slave.
`timescale 1ns/100ps
`default_nettype none
`include "bwc_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module bwc_crc16_top_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] sum;
  int num_errors = 0, checks = 0, cycles = 0;
  // Single-byte results from a zero start, then the four-byte chains.
  logic [15:0] one_tab [2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063,
    16'h4084, 16'h50A5, 16'h60C6, 16'h70E7}, '{16'h0000, 16'h8005,
    16'h800F, 16'h000A, 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
  logic [15:0] seq_tab [2][4] = '{'{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
    '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
  logic [7:0] seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
  always #2 aclk = ~aclk;
  bwc_crc16_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ==========================================================
  // Bus tasks
  // Handshakes are judged at the falling edge, since inputs move only
  // on rising edges; that avoids racing the slave's own updates.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    while (tb !== 1'b1);
    bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      resp = rresp;
      sum[7:0] = rdata[7:0];
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end
    while (tr !== 1'b1);
    `CHK("rdata upper", 24'h000000, rdata[31:8])
    rready <= 0;
  endtask
  // Reads the checksum pair, high byte first.
  task automatic rd_sum();
    logic [7:0] hi;
    rd(`BWC_OFF_SUM_HIGH);
    hi = sum[7:0];
    rd(`BWC_OFF_SUM_LOW);
    sum = {hi, sum[7:0]};
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_and_control();
    rd_sum();
    `CHK("reset sum", 16'h0000, sum)
    rd(`BWC_OFF_CONTROL);
    `CHK("reset control", 8'h00, sum[7:0])
    `CHK("rresp okay", `BWC_RESP_OKAY, resp)
    rd(`BWC_OFF_INPUT);
    `CHK("reset input", 8'h00, sum[7:0])
    wr(`BWC_OFF_CONTROL, 8'hFF);
    `CHK("bresp okay", `BWC_RESP_OKAY, resp)
    rd(`BWC_OFF_CONTROL);
    `CHK("control", 8'h01, sum[7:0])
  endtask
  task automatic t_crc();
    for (int p = 0; p < 2; p++)
    begin
      wr(`BWC_OFF_CONTROL, 8'(p));
      for (int b = 0; b < 8; b++)
      begin
        wr(`BWC_OFF_SUM_LOW, 8'h00);
        wr(`BWC_OFF_SUM_HIGH, 8'h00);
        wr(`BWC_OFF_INPUT, 8'(b));
        rd_sum();
        `CHK("one byte", one_tab[p][b], sum)
      end
      // The chain must start from zero, not from the last single byte.
      wr(`BWC_OFF_SUM_LOW, 8'h00);
      wr(`BWC_OFF_SUM_HIGH, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
        wr(`BWC_OFF_INPUT, seq_in[i]);
        rd_sum();
        `CHK("chain", seq_tab[p][i], sum)
      end
      rd(`BWC_OFF_INPUT);
      `CHK("input byte", 8'h12, sum[7:0])
    end
  endtask
  task automatic t_pair_and_unmapped();
    wr(`BWC_OFF_SUM_LOW, 8'h34);
    wr(`BWC_OFF_SUM_HIGH, 8'h12);
    rd_sum();
    `CHK("pair", 16'h1234, sum)
    wr(4'h2, 8'h55);
    `CHK("bresp", `BWC_RESP_SLVERR, resp)
    rd(4'h6);
    `CHK("rresp", `BWC_RESP_SLVERR, resp)
    `CHK("unmapped rdata", 8'h00, sum[7:0])
    rd_sum();
    `CHK("pair kept", 16'h1234, sum)
  endtask
  // ==========================================================
  // Run control
  task automatic end_of_test();
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset_and_control();
    t_crc();
    t_pair_and_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire

// *** bwc_crc_step.sv ***
// Combinational eight-bit CRC16 update for the two fixed polynomials.
`timescale 1ns/100ps
`default_nettype none
`include "bwc_consts.svh"
module bwc_crc_step
  import bwc_pkg::*;
(
  input wire logic [15:0] sum_in,
  input wire logic [7:0] data_in,
  input wire logic polynomial_select_sel,
  output logic [15:0] sum_out
);
  // Only two constants are selectable; no other polynomial can be reached.
  wire logic [15:0] polynomial_select_value;
  assign polynomial_select_value = polynomial_select_sel ? `BWC_POLYNOMIAL_SELECT_CRC16 : `BWC_POLYNOMIAL_SELECT_CCITT;
  // Stage zero mixes the byte into the high half of the checksum.
  wire logic [15:0] stage [0:`BWC_BITS_PER_BYTE];
  assign stage[0] = sum_in ^ {data_in, `BWC_BYTE_ZERO};
  // Eight unrolled bit steps keep the update to one clock.
  genvar i;
  generate
    for (i = 0; i < `BWC_BITS_PER_BYTE; i = i + 1)
    begin : g_bit
      wire logic [15:0] shifted;
      assign shifted = {stage[i][14:0], 1'b0};
      // The bit shifted out of the top decides the XOR.
      assign stage[i+1] = stage[i][15] ? (shifted ^ polynomial_select_value) : shifted;
    end
  endgenerate
  assign sum_out = stage[`BWC_BITS_PER_BYTE];
endmodule
`default_nettype wire

// *** bwc_decode.sv ***
// Word address decoder for the CRC register map.
`timescale 1ns/100ps
`default_nettype none
`include "bwc_consts.svh"
module bwc_decode
  import bwc_pkg::*;
(
  input wire logic [3:0] addr,
  output logic hit,
  output bwc_reg_type sel
);
  // Map only the four word offsets; anything else misses.
  assign hit = (addr == `BWC_OFF_CONTROL) || (addr == `BWC_OFF_INPUT) ||
               (addr == `BWC_OFF_SUM_LOW) || (addr == `BWC_OFF_SUM_HIGH);
  assign sel = bwc_reg_type'(addr[`BWC_ADDR_MSB:`BWC_ADDR_LSB]);
endmodule
`default_nettype wire

// *** bwc_pkg.sv ***
// Types shared by the byte-wise CRC16 generator modules.
package bwc_pkg;
  // One register write request as seen by the register file.
  typedef struct packed {
    logic [1:0] index;
    logic [7:0] data;
    logic strobe;
  } bwc_wreq_type;
  // Register decode result.
  typedef enum logic [1:0] {
    BWC_REG_CONTROL,
    BWC_REG_INPUT,
    BWC_REG_SUM_LOW,
    BWC_REG_SUM_HIGH
  } bwc_reg_type;
endpackage
